// file: logic/cic_pkg.sv
// Constants shared by the codec configuration port controller.
package cic_pkg;

    // Reference clock period
    localparam int CLK_NS = 50;

    // Fastest transfer rate the codec port accepts, and the bit period it implies
    localparam int MAX_KBPS = 100;
    localparam int BIT_NS = 1000000 / MAX_KBPS;

    // Half of a bit period: clock low and clock high each take this long
    localparam int HALF_NS = BIT_NS / 2;

    // Data hold after the clock falls before the data line may change
    localparam int HOLD_NS = 100;

    // Bus free time between a stop and the next start
    localparam int FREE_NS = 4700;

    // Timer width and derived cycle counts (least times round up)
    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] HALF_CYC = TMR_W'((HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] HOLD_CYC = TMR_W'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] FREE_CYC = TMR_W'((FREE_NS + CLK_NS - 1) / CLK_NS);

    // Fixed upper six bits of the codec's seven-bit target address
    localparam logic [5:0] ADDR_HI = 6'h08;

    // Direction bit values
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    // Bit position of the acknowledge slot within a byte
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // Byte segments of one transaction
    localparam logic [1:0] SEG_ADDR = 2'h0;
    localparam logic [1:0] SEG_INDEX = 2'h1;
    localparam logic [1:0] SEG_THIRD = 2'h2;
    localparam logic [1:0] SEG_RDATA = 2'h3;

    // Controller states, one-hot
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_START = 9'h002,
        ST_BIT_LOW = 9'h004,
        ST_BIT_HIGH = 9'h008,
        ST_RS_LOW = 9'h010,
        ST_RS_HIGH = 9'h020,
        ST_STOP_LOW = 9'h040,
        ST_STOP_HIGH = 9'h080,
        ST_FREE = 9'h100
    } cic_state_t;

endpackage

// file: logic/cic_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module cic_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Raw pin levels
    input wire logic [1:0] pin_raw,
    // Filtered levels
    output logic [1:0] pin_level
);

    logic [1:0] stage1;
    logic [1:0] stage2;
    logic [1:0] stage3;

    // Idle bus level is high, so every stage resets high
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_bit
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    stage1[g] <= 1'b1;
                    stage2[g] <= 1'b1;
                    stage3[g] <= 1'b1;
                    pin_level[g] <= 1'b1;
                end else begin
                    stage1[g] <= pin_raw[g];
                    stage2[g] <= stage1[g];
                    stage3[g] <= stage2[g];
                    // A single-cycle glitch between stages two and three is ignored
                    if (stage2[g] == stage3[g]) begin
                        pin_level[g] <= stage3[g];
                    end
                end
            end
        end
    endgenerate

endmodule

// file: logic/cic_master.sv
// Bus master that writes and reads codec configuration registers over the two-wire port.
`timescale 1ns/1ps

// Behaviour
// - Bytes go most significant bit first; bits are valid while clock is high.
// - Address and index bytes are acknowledged by the codec pulling data low.
// - The clock never runs faster than one hundred kilobits per second.
// - Each transaction opens with data falling while clock is high.
// - Each transaction closes with data rising while clock is high.
// - First byte holds seven address bits then direction, zero write, one read.
// - After the acknowledged address, bytes move in the chosen direction.
// - Write sends address with zero, index, then one data byte.
// - Read sends address and index, repeated start, address with one, reads byte.
// - No acknowledge follows the data byte of a write or a read.
module cic_master (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Command request
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_index,
    input wire logic [7:0] cmd_wdata,
    // Strap level of the codec's address_select_pin
    input wire logic address_select_pin,
    // Command answer
    output logic rsp_valid,
    output logic rsp_nack,
    output logic [7:0] rsp_rdata,
    // Clock line, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // Data line, open drain
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    cic_pkg::cic_state_t state;
    cic_pkg::cic_state_t next_state;

    logic [cic_pkg::TMR_W-1:0] tmr;
    logic [cic_pkg::TMR_W-1:0] limit;
    logic [7:0] shreg;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [3:0] bit_cnt;
    logic [1:0] seg;
    logic rd;
    logic asel;
    logic scl_drive;
    logic sda_drive;
    logic [1:0] pin_level;
    logic scl_s;
    logic sda_s;
    logic run;
    logic last;
    logic accept;
    logic bit_end;
    logic ack_slot;
    logic seg_has_ack;
    logic seg_tx;
    logic byte_last;
    logic acked;

    // Pins arrive from outside, so both pass the three-stage filter
    cic_sync u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_raw({scl_in, sda_in}),
        .pin_level(pin_level)
    );

    assign scl_s = pin_level[1];
    assign sda_s = pin_level[0];

    // Open-drain lines only ever pull low; releasing lets the pull-up win
    assign scl_out = 1'b0;
    assign scl_oe = scl_drive;
    assign sda_out = 1'b0;
    assign sda_oe = sda_drive;

    // A new command waits for an idle controller and a quiet bus
    assign cmd_ready = (state == cic_pkg::ST_IDLE) && scl_s && sda_s;
    assign accept = cmd_valid && cmd_ready;

    // Phase length: the free gap after a stop, otherwise half a bit period
    assign limit = (state == cic_pkg::ST_FREE) ? cic_pkg::FREE_CYC : cic_pkg::HALF_CYC;

    // High phases count only once the line is seen high, so a held clock stretches the bit
    always_comb begin
        run = 1'b1;
        if ((state == cic_pkg::ST_BIT_HIGH) || (state == cic_pkg::ST_RS_HIGH) ||
            (state == cic_pkg::ST_STOP_HIGH)) begin
            run = scl_s;
        end
    end

    assign last = run && (tmr == limit - 1'b1);

    // Byte bookkeeping
    assign bit_end = (state == cic_pkg::ST_BIT_HIGH) && last;
    assign ack_slot = (bit_cnt == cic_pkg::ACK_SLOT);
    // The write data byte and the read data byte carry no acknowledge slot
    assign seg_has_ack = (seg == cic_pkg::SEG_ADDR) || (seg == cic_pkg::SEG_INDEX) ||
                         ((seg == cic_pkg::SEG_THIRD) && rd);
    assign seg_tx = (seg != cic_pkg::SEG_RDATA);
    assign byte_last = ack_slot || ((bit_cnt == cic_pkg::LAST_BIT) && !seg_has_ack);
    assign acked = !sda_s;

    // Next state, stepping on the end of each timed phase
    always_comb begin
        next_state = state;
        unique case (state)
            cic_pkg::ST_IDLE: begin
                if (accept) begin
                    next_state = cic_pkg::ST_START;
                end
            end
            cic_pkg::ST_START: begin
                if (last) begin
                    next_state = cic_pkg::ST_BIT_LOW;
                end
            end
            cic_pkg::ST_BIT_LOW: begin
                if (last) begin
                    next_state = cic_pkg::ST_BIT_HIGH;
                end
            end
            cic_pkg::ST_BIT_HIGH: begin
                if (last) begin
                    if (!byte_last) begin
                        next_state = cic_pkg::ST_BIT_LOW;
                    end else if (!ack_slot) begin
                        // Data byte done, no acknowledge slot: close at once
                        next_state = cic_pkg::ST_STOP_LOW;
                    end else if (!acked) begin
                        // Nobody answered: abandon with a stop
                        next_state = cic_pkg::ST_STOP_LOW;
                    end else if ((seg == cic_pkg::SEG_INDEX) && rd) begin
                        next_state = cic_pkg::ST_RS_LOW;
                    end else begin
                        next_state = cic_pkg::ST_BIT_LOW;
                    end
                end
            end
            cic_pkg::ST_RS_LOW: begin
                if (last) begin
                    next_state = cic_pkg::ST_RS_HIGH;
                end
            end
            cic_pkg::ST_RS_HIGH: begin
                if (last) begin
                    next_state = cic_pkg::ST_START;
                end
            end
            cic_pkg::ST_STOP_LOW: begin
                if (last) begin
                    next_state = cic_pkg::ST_STOP_HIGH;
                end
            end
            cic_pkg::ST_STOP_HIGH: begin
                if (last) begin
                    next_state = cic_pkg::ST_FREE;
                end
            end
            cic_pkg::ST_FREE: begin
                if (last) begin
                    next_state = cic_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = cic_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= cic_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Phase timer restarts on every state change
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tmr <= '0;
        end else if ((state == cic_pkg::ST_IDLE) || last) begin
            tmr <= '0;
        end else if (run) begin
            tmr <= tmr + 1'b1;
        end
    end

    // Command capture; the strap level is sampled per command since the pin also carries audio
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd <= cic_pkg::DIR_WRITE;
            idx <= 8'h00;
            wdata <= 8'h00;
            asel <= 1'b0;
        end else if (accept) begin
            rd <= cmd_read;
            idx <= cmd_index;
            wdata <= cmd_wdata;
            asel <= address_select_pin;
        end
    end

    // Shift register, bit counter and byte segment
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shreg <= 8'hff;
            bit_cnt <= 4'h0;
            seg <= cic_pkg::SEG_ADDR;
        end else if (accept) begin
            shreg <= {cic_pkg::ADDR_HI, address_select_pin, cic_pkg::DIR_WRITE};
            bit_cnt <= 4'h0;
            seg <= cic_pkg::SEG_ADDR;
        end else if (bit_end) begin
            if (ack_slot) begin
                bit_cnt <= 4'h0;
                seg <= seg + 1'b1;
                if (seg == cic_pkg::SEG_ADDR) begin
                    shreg <= idx;
                end else if ((seg == cic_pkg::SEG_INDEX) && !rd) begin
                    shreg <= wdata;
                end else if (seg == cic_pkg::SEG_INDEX) begin
                    shreg <= {cic_pkg::ADDR_HI, asel, cic_pkg::DIR_READ};
                end else begin
                    // Receive byte: keep our side released
                    shreg <= 8'hff;
                end
            end else begin
                // Shift out the top bit, shift in the sampled line level
                shreg <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    // Clock line: pulled low in every low phase, released otherwise
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_drive <= 1'b0;
        end else begin
            scl_drive <= (next_state == cic_pkg::ST_BIT_LOW) ||
                         (next_state == cic_pkg::ST_RS_LOW) ||
                         (next_state == cic_pkg::ST_STOP_LOW);
        end
    end

    // Data line: bits change only in low phases after the hold time; start and stop change it while clock is high
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_drive <= 1'b0;
        end else if ((next_state == cic_pkg::ST_START) && (state != cic_pkg::ST_START)) begin
            sda_drive <= 1'b1;
        end else if ((state == cic_pkg::ST_BIT_LOW) && (tmr == cic_pkg::HOLD_CYC - 1'b1)) begin
            // Release for the acknowledge slot and for every bit of the read byte
            sda_drive <= seg_tx && !ack_slot && !shreg[7];
        end else if ((state == cic_pkg::ST_RS_LOW) && (tmr == cic_pkg::HOLD_CYC - 1'b1)) begin
            sda_drive <= 1'b0;
        end else if ((state == cic_pkg::ST_STOP_LOW) && (tmr == cic_pkg::HOLD_CYC - 1'b1)) begin
            sda_drive <= 1'b1;
        end else if ((state == cic_pkg::ST_STOP_HIGH) && last) begin
            sda_drive <= 1'b0;
        end
    end

    // Answer: missing acknowledge flag, read byte and completion pulse
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_nack <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= (state == cic_pkg::ST_FREE) && last;
            if (accept) begin
                rsp_nack <= 1'b0;
            end else if (bit_end && ack_slot && !acked) begin
                rsp_nack <= 1'b1;
            end
            if (bit_end && byte_last && (seg == cic_pkg::SEG_RDATA)) begin
                rsp_rdata <= {shreg[6:0], sda_s};
            end
        end
    end

endmodule

// file: verif/cic_master_checker.sv
// Port assertions for the configuration port master.
`timescale 1ns/1ps
module cic_master_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Command side
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_rdata,
    // Bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    logic [7:0] lo_cnt;
    logic [7:0] hi_cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Phase lengths; saturating so long idle spans cannot wrap round
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lo_cnt <= 8'h00;
            hi_cnt <= 8'h00;
        end else begin
            lo_cnt <= !scl_oe ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
            hi_cnt <= scl_oe ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
        end
    end
    a_low_phase_min: assert property ($fell(scl_oe) |-> lo_cnt >= 8'h64)
        else $error("clock low phase too short");
    a_high_phase_min: assert property ($rose(scl_oe) |-> hi_cnt >= 8'h64)
        else $error("clock high phase too short");
    a_take_starts: assert property (cmd_valid && cmd_ready |=> sda_oe && !scl_oe)
        else $error("take did not open with a start");
    a_start_hold: assert property ($rose(sda_oe) && !scl_oe |-> (sda_oe && !scl_oe)[*8])
        else $error("start not held with clock high");
    a_stop_done: assert property ($fell(sda_oe) && !scl_oe |-> ##[92:97] rsp_valid)
        else $error("stop not followed by completion");
    a_ready_idle: assert property (cmd_ready |-> !scl_oe && !sda_oe && scl_in && sda_in)
        else $error("ready while bus not idle");
    // The byte lands as the stop's low phase begins, so look at the sampling cycle
    a_rdata_released: assert property ($changed(rsp_rdata) |-> !$past(sda_oe) && !$past(scl_oe))
        else $error("read byte taken while driving");
    a_done_released: assert property (rsp_valid |-> !scl_oe && !$past(sda_oe, 90))
        else $error("completion without bus free time");
endmodule

bind cic_master cic_master_checker chk_u (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
);

// file: verif/cic_codec_model.sv
// Behavioural codec on the far side of the configuration port.
`timescale 1ns/1ps
module cic_codec_model (
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    // Strap level and clock stretch, zero for prompt answers
    input wire logic strap,
    input wire logic [15:0] stretch_ns,
    // Open-drain pulls, high while pulling low
    output logic scl_pull,
    output logic sda_pull
);
    logic [7:0] regs [256];
    logic [7:0] sh;
    logic [7:0] idx;
    logic act = 1'b0;
    logic rd;
    logic out;
    int n;
    int seg;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // Start or repeated start: data falls with clock high
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        n = 0;
        seg = 0;
        rd = 1'b0;
        out = 1'b0;
    end
    // Stop lets go of everything
    always @(posedge sda) if (scl === 1'b1) begin
        act = 1'b0;
        sda_pull = 1'b0;
    end
    // Bits are taken while the clock is high, first bit is the top one
    always @(posedge scl) if (act) begin
        if (!out && n < 8) sh = {sh[6:0], sda};
        n++;
    end
    // Data only changes after the clock falls
    always @(negedge scl) if (act) begin
        if (out) begin
            sda_pull = (n < 8) ? ~regs[idx][7-n] : 1'b0;
            act = (n < 8);
        end else if (n == 8) begin
            if (seg == 0) begin
                act = (sh[7:1] == {6'h08, strap});
                sda_pull = act;
                rd = sh[0];
            end else if (seg == 1) begin
                idx = sh;
                sda_pull = 1'b1;
            end else begin
                regs[idx] = sh;
                act = 1'b0;
            end
        end else if (n == 9) begin
            n = 0;
            seg++;
            out = rd;
            sda_pull = rd & ~regs[idx][7];
        end
    end
    // Slow answers: hold the clock low past the master's own low phase
    always @(negedge scl) if (stretch_ns != 16'h0000) begin
        scl_pull = 1'b1;
        #(stretch_ns) scl_pull = 1'b0;
    end
endmodule

// file: verif/cic_master_bench.sv
// Self-checking bench for the configuration port master.
`timescale 1ns/1ps
module cic_master_bench;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [7:0] cmd_index = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic sel_pin = 1'b0;
    logic strap = 1'b0;
    logic [15:0] stretch_ns = 16'h0000;
    logic cmd_ready;
    logic rsp_valid;
    logic rsp_nack;
    logic [7:0] rsp_rdata;
    logic scl_oe;
    logic sda_oe;
    logic scl_o;
    logic sda_o;
    logic scl_pull;
    logic sda_pull;
    logic [7:0] wbyte;
    int pulses = 0;
    int error_cnt = 0;
    int num_checks = 0;
    // Pull-ups: an enabled master shows its output level, the codec only pulls low
    wire scl_w = (scl_oe ? scl_o : 1'b1) & ~scl_pull;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

    always #25 ref_clk = ~ref_clk;

    cic_master dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_index(cmd_index),
        .cmd_wdata(cmd_wdata), .address_select_pin(sel_pin), .rsp_valid(rsp_valid),
        .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata), .scl_in(scl_w), .scl_out(scl_o),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe));
    cic_codec_model codec_u (.scl(scl_w), .sda(sda_w), .strap(strap),
        .stretch_ns(stretch_ns), .scl_pull(scl_pull), .sda_pull(sda_pull));

    // Wire watcher: clock pulses and first byte since the latest start
    always @(negedge sda_w) if (scl_w === 1'b1) pulses = 0;
    always @(posedge scl_w) begin
        if (pulses < 8) wbyte = {wbyte[6:0], sda_w};
        pulses++;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One command: offer it, wait for the take, then for completion
    task automatic run(input logic rd, input logic [7:0] idx, input logic [7:0] wd);
        int i;
        int j;
        cmd_read = rd;
        cmd_index = idx;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        for (i = 0; i < 20000; i++) begin
            @(posedge ref_clk);
            if (cmd_ready === 1'b1) break;
        end
        #1 cmd_valid = 1'b0;
        for (j = 0; j < 20000; j++) begin
            @(posedge ref_clk);
            if (rsp_valid === 1'b1) break;
        end
        #1;
        if (i == 20000 || j == 20000) begin
            error_cnt++;
            $display("BAD handshake wait ran out");
            end_sim();
        end
    endtask

    task automatic t_reset();
        chk("nack", 8'h00, {7'h00, rsp_nack});
        chk("rdata", 8'h00, rsp_rdata);
        chk("pulls", 8'h00, {6'h00, scl_oe, sda_oe});
        chk("outs", 8'h00, {6'h00, scl_o, sda_o});
        $display("reset test done");
    endtask

    // Write then an immediate read back of the same register
    task automatic t_wr_rd(input logic sel, input logic [7:0] idx, input logic [7:0] dat);
        sel_pin = sel;
        strap = sel;
        run(1'b0, idx, dat);
        chk("nack", 8'h00, {7'h00, rsp_nack});
        chk("addr", {6'h08, sel, 1'b0}, wbyte);
        chk("pulses", 8'h1b, 8'(pulses));
        run(1'b1, idx, 8'h00);
        chk("nack", 8'h00, {7'h00, rsp_nack});
        chk("rdata", dat, rsp_rdata);
        chk("addr", {6'h08, sel, 1'b1}, wbyte);
        chk("pulses", 8'h12, 8'(pulses));
        $display("write read test done");
    endtask

    // Strap mismatch: no acknowledge, early stop, read byte kept
    task automatic t_nack();
        sel_pin = 1'b0;
        strap = 1'b1;
        run(1'b0, 8'h11, 8'h22);
        chk("nack", 8'h01, {7'h00, rsp_nack});
        chk("pulses", 8'h0a, 8'(pulses));
        chk("rdata", 8'ha5, rsp_rdata);
        $display("nack test done");
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        t_reset();
        t_wr_rd(1'b0, 8'h3c, 8'ha5);
        t_nack();
        t_wr_rd(1'b1, 8'hff, 8'h5a);
        stretch_ns = 16'h1b58;
        t_wr_rd(1'b0, 8'h00, 8'hc3);
        end_sim();
    end
endmodule
